// ==== dv/ssh_standby_ctl_test.sv ====
// Purpose: self-checking bench for the standby control block
// Assumes: STAB_BASE shortened to 8 cycles; ring pin period 6 clocks
// Notes:   read data checked from a queue of expected values
`timescale 1ns/10ps
module ssh_standby_ctl_test;
  localparam int SB = 8;
  localparam int RP = 6;
  logic                  clk_sys = 1'b0;
  logic                  nrst = 1'b0;
  logic [3:0]            avs_address = 4'h0;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = 32'h0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  ssh_pkg::ssh_clk_src_t cpu_clk_src = ssh_pkg::SRC_MAIN;
  logic                  stop_req = 1'b0;
  logic                  halt_req = 1'b0;
  logic                  irq_pending = 1'b0;
  logic                  main_osc_ok_pin = 1'b1;
  logic                  ring_tick_pin = 1'b0;
  logic                  ring_sw_stop_ok_pin = 1'b0;
  ssh_pkg::ssh_osc_ctl_t osc_ctl;
  ssh_pkg::ssh_state_t   standby_state;
  int                    fails = 0;
  int                    tests_run = 0;
  int                    rcnt = 0;
  int                    hold_cyc = 0;
  int                    n;
  int                    es;
  logic [31:0]           exp_q[$];

  ssh_standby_ctl #(.STAB_BASE(SB)) ssh_standby_ctl_i (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_clk_src(cpu_clk_src),
    .stop_req(stop_req), .halt_req(halt_req), .irq_pending(irq_pending),
    .main_osc_ok_pin(main_osc_ok_pin), .ring_tick_pin(ring_tick_pin),
    .ring_sw_stop_ok_pin(ring_sw_stop_ok_pin), .osc_ctl(osc_ctl),
    .standby_state(standby_state));

  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // free-running ring oscillator seen as data; hold cycles counted
  always @(posedge clk_sys) begin
    rcnt <= (rcnt == RP - 1) ? 0 : rcnt + 1;
    ring_tick_pin <= (rcnt >= 2);
    if (standby_state === ssh_pkg::ST_STOP) begin
      hold_cyc <= 0;
    end else if (standby_state === ssh_pkg::ST_RING_HOLD) begin
      hold_cyc <= hold_cyc + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // read data monitor takes the oldest expected value at the accepting edge
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        chk(avs_readdata, exp_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) chk(32'h1, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic req(input logic s, input logic h);
    @(posedge clk_sys);
    stop_req <= s;
    halt_req <= h;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    halt_req <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic wait_st(input ssh_pkg::ssh_state_t s, output int c);
    c = 0;
    while (standby_state !== s && c < 3000) begin
      @(negedge clk_sys);
      c++;
    end
    if (c >= 3000) chk(32'h1, 32'h0);
  endtask

  task automatic irq_set(input logic v);
    @(posedge clk_sys);
    irq_pending <= v;
  endtask

  task automatic st(input ssh_pkg::ssh_state_t s);
    chk({29'h0, standby_state}, {29'h0, s});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    fails++;
    close_out();
  end

  initial begin
    void'($urandom(63751));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    wait_st(ssh_pkg::ST_RUN, n);
    chk({31'h0, n >= 16 * SB}, 32'h1);
    rd(ssh_pkg::ADDR_SEL, 32'h4);
    rd(ssh_pkg::ADDR_STAT, 32'h1f);
    rd(ssh_pkg::ADDR_CTRL, 32'h0);
    rd(4'h2, 32'h0);
    rd(ssh_pkg::ADDR_MODE, 32'h0);
    // stop bit refused, then accepted, then cleared
    bus(1'b1, ssh_pkg::ADDR_CTRL, 32'h1);
    rd(ssh_pkg::ADDR_CTRL, 32'h0);
    chk({31'h0, osc_ctl.internal_ring_oscillator_en}, 32'h1);
    ring_sw_stop_ok_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    bus(1'b1, ssh_pkg::ADDR_CTRL, 32'h1);
    rd(ssh_pkg::ADDR_CTRL, 32'h1);
    chk({31'h0, osc_ctl.internal_ring_oscillator_en}, 32'h0);
    bus(1'b1, ssh_pkg::ADDR_CTRL, 32'h0);
    // STOP on the crystal for select values 0 to 4 and one random value from 5 to 7
    for (int s = 0; s < 6; s++) begin
      es = (s < 5) ? s : 4;
      bus(1'b1, ssh_pkg::ADDR_SEL, (s < 5) ? s : 5 + $urandom % 3);
      cpu_clk_src <= ssh_pkg::SRC_MAIN;
      req(1'b1, 1'b0);
      st(ssh_pkg::ST_STOP);
      chk({29'h0, osc_ctl}, 32'h2);
      @(posedge clk_sys);
      main_osc_ok_pin <= 1'b0;
      irq_set(1'b1);
      wait_st(ssh_pkg::ST_OSC_WAIT, n);
      chk({31'h0, osc_ctl.main_osc_en}, 32'h1);
      irq_set(1'b0);
      repeat (10) @(posedge clk_sys);
      main_osc_ok_pin <= 1'b1;
      wait_st(ssh_pkg::ST_RUN, n);
      chk({31'h0, n >= (SB << es) && n <= (SB << es) + 5},
          32'h1);
      chk({31'h0, osc_ctl.cpu_clk_en}, 32'h1);
      rd(ssh_pkg::ADDR_STAT, (32'h1f << (4 - es)) & 32'h1f);
    end
    // STOP on the ring clock; one ring period may already be under way
    cpu_clk_src <= ssh_pkg::SRC_RING;
    req(1'b1, 1'b0);
    st(ssh_pkg::ST_STOP);
    chk({29'h0, osc_ctl}, 32'h2);
    rd(ssh_pkg::ADDR_MODE, 32'h12);
    irq_set(1'b1);
    wait_st(ssh_pkg::ST_RING_HOLD, n);
    irq_set(1'b0);
    chk({31'h0, osc_ctl.internal_ring_oscillator_en}, 32'h1);
    chk({31'h0, osc_ctl.cpu_clk_en}, 32'h0);
    wait_st(ssh_pkg::ST_RUN, n);
    chk({31'h0, hold_cyc > 16 * RP && hold_cyc <= 17 * RP},
        32'h1);
    // STOP refused on the subsystem clock
    @(posedge clk_sys);
    cpu_clk_src <= ssh_pkg::SRC_SUB;
    req(1'b1, 1'b0);
    st(ssh_pkg::ST_RUN);
    // HALT from every source
    for (int c = 0; c < 3; c++) begin
      @(posedge clk_sys);
      cpu_clk_src <= ssh_pkg::ssh_clk_src_t'(c);
      req(1'b0, 1'b1);
      st(ssh_pkg::ST_HALT);
      chk({31'h0, osc_ctl.cpu_clk_en}, 32'h0);
      irq_set(1'b1);
      wait_st(ssh_pkg::ST_RUN, n);
      irq_set(1'b0);
    end
    // pending interrupt turns STOP into HALT and cancels HALT
    @(posedge clk_sys);
    cpu_clk_src <= ssh_pkg::SRC_MAIN;
    irq_set(1'b1);
    req(1'b1, 1'b0);
    st(ssh_pkg::ST_HALT);
    wait_st(ssh_pkg::ST_RUN, n);
    req(1'b0, 1'b1);
    st(ssh_pkg::ST_RUN);
    irq_set(1'b0);
    repeat (2) @(posedge clk_sys);
    close_out();
  end
endmodule // ssh_standby_ctl_test

// ==== logic/ssh_pkg.sv ====
// Purpose: shared constants and types of the standby control block
// Assumes: 32-bit Avalon-MM register window, byte addressed
// Notes:   all offsets are byte addresses of aligned words
package ssh_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SEL  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_MODE = 4'hc;
  // field positions
  localparam int CTRL_RING_STOP_POS = 0;
  localparam int MODE_SRC_POS   = 4;
  // stabilization steps, base wait in clk_sys cycles, ring hold periods
  localparam int         STAB_STEPS        = 5;
  localparam int         STAB_BASE_CYC     = 2048;
  localparam logic [4:0] RING_HOLD_PERIODS = 5'h11;
  // values after reset
  localparam logic [2:0] SEL_RST  = 3'h4;
  localparam logic [4:0] STAT_RST = 5'h00;
  localparam logic [4:0] HOLD_RST = 5'h00;
  // crystal on, ring on, cpu clock held
  localparam logic [2:0] OSC_CTL_RST = 3'h6;

  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00,
    SRC_RING = 2'b01,
    SRC_SUB  = 2'b10
  } ssh_clk_src_t;

  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_HALT      = 3'b001,
    ST_STOP      = 3'b010,
    ST_OSC_WAIT  = 3'b011,
    ST_RING_HOLD = 3'b100
  } ssh_state_t;

  typedef struct packed {
    logic main_osc_en;
    logic internal_ring_oscillator_en;
    logic cpu_clk_en;
  } ssh_osc_ctl_t;
endpackage

// ==== logic/ssh_stab_cnt.sv ====
// Purpose: main crystal stabilization counter with status bits
// Assumes: osc_ok is already synchronised to clk_sys
// Notes:   counting stops once the selected wait has elapsed
`timescale 1ns/10ps
module ssh_stab_cnt #(
  parameter int STAB_BASE = ssh_pkg::STAB_BASE_CYC,
  parameter int CW        = 16
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // control
  input  wire logic                          clear,
  input  wire logic                          osc_ok,
  input  wire logic [2:0]                    sel,
  // result
  output logic [ssh_pkg::STAB_STEPS-1:0]     status,
  output logic                               done
);
  logic [CW-1:0]                  cnt_r;
  logic [CW-1:0]                  cnt_nxt;
  logic [ssh_pkg::STAB_STEPS-1:0] status_r;
  logic [ssh_pkg::STAB_STEPS-1:0] status_nxt;
  logic [ssh_pkg::STAB_STEPS-1:0] hit;
  logic [2:0]                     sel_eff;

  ////////////////////////////////////////////////////////////////////////////
  // step i reached maps to status bit from the top down
  genvar i;
  generate
    for (i = 0; i < ssh_pkg::STAB_STEPS; i++) begin : g_step
      assign hit[ssh_pkg::STAB_STEPS-1-i] =
        (cnt_r >= CW'(STAB_BASE << i)); // see [R7]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    sel_eff    = (sel > 3'h4) ? 3'h4 : sel;
    done       = hit[3'h4 - sel_eff];
    cnt_nxt    = cnt_r;
    status_nxt = status_r | hit; // see [R7]
    if (clear) begin
      cnt_nxt    = '0;
      status_nxt = ssh_pkg::STAT_RST;
    end else if (osc_ok && !done) begin // see [R8] [R10]
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r    <= '0;
      status_r <= ssh_pkg::STAT_RST;
    end else begin
      cnt_r    <= cnt_nxt;
      status_r <= status_nxt;
    end
  end

  assign status = status_r;
endmodule // ssh_stab_cnt

// ==== logic/ssh_standby_ctl.sv ====
// Purpose: STOP/HALT standby control with oscillator stabilization wait
// Assumes: CPU logic on clk_sys gives source, requests and irq_pending
// Notes:   oscillator status pins are asynchronous and synchronised here
// Functional notes
// [R1] STOP is entered only while the CPU runs on the main crystal or ring.
// [R2] HALT is entered from the main crystal, ring or subsystem clock.
// [R3] STOP on the ring clock halts the crystal and keeps the ring running.
// [R4] a ring oscillator already running keeps running throughout STOP.
// [R5] after STOP on the ring clock the CPU waits 17 ring periods.
// [R6] the ring stop bit is writable only when the mask option allows it.
// [R7] status bits set one by one from the top bit and stay set.
// [R8] the crystal counter counts only within the selected wait time.
// [R9] software keeps its desired status time within the selected wait.
// [R10] the release wait counts from oscillation start, for reset or irq.
// [R11] software stops peripherals before entering STOP.
// [R12] software clears the conversion run bit before HALT or STOP.
// [R13] an unmasked pending interrupt cancels standby, STOP falls to HALT.
// [R14] software programs the select setting before STOP on the crystal.
// [R15] on release the oscillator restarts, waits, then the CPU resumes.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ssh_standby_ctl #(
  parameter int STAB_BASE = ssh_pkg::STAB_BASE_CYC
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // avalon-mm slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  // cpu side
  input  wire ssh_pkg::ssh_clk_src_t cpu_clk_src,
  input  wire logic                  stop_req,
  input  wire logic                  halt_req,
  input  wire logic                  irq_pending,
  // oscillator pins
  input  wire logic                  main_osc_ok_pin,
  input  wire logic                  ring_tick_pin,
  input  wire logic                  ring_sw_stop_ok_pin,
  // outputs
  output ssh_pkg::ssh_osc_ctl_t      osc_ctl,
  output ssh_pkg::ssh_state_t        standby_state
);
  ssh_pkg::ssh_state_t   state_r, state_nxt;
  ssh_pkg::ssh_clk_src_t src_r, src_nxt;
  ssh_pkg::ssh_osc_ctl_t osc_ctl_r, osc_ctl_nxt;
  logic [4:0]  hold_cnt_r, hold_cnt_nxt;
  logic        ring_stop_r, ring_stop_nxt;
  logic [2:0]  sel_r, sel_nxt;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0]  sync1_r, sync2_r;
  logic        ring_d_r;
  logic        osc_ok_s, ring_edge, mask_ok_s;
  logic        stab_clear, stab_done;
  logic [4:0]  stab_status;
  logic        wr_go;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, edge detect reads only the second stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_r  <= 3'h0;
      sync2_r  <= 3'h0;
      ring_d_r <= 1'b0;
    end else begin
      sync1_r  <= {ring_sw_stop_ok_pin, ring_tick_pin, main_osc_ok_pin};
      sync2_r  <= sync1_r;
      ring_d_r <= sync2_r[1];
    end
  end
  assign osc_ok_s  = sync2_r[0];
  assign ring_edge = sync2_r[1] & ~ring_d_r;
  assign mask_ok_s = sync2_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // standby state machine
  always_comb begin
    state_nxt    = state_r;
    src_nxt      = src_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      ssh_pkg::ST_RUN: begin
        if (stop_req && irq_pending) begin
          state_nxt = ssh_pkg::ST_HALT; // see [R13]
        end else if (stop_req && cpu_clk_src != ssh_pkg::SRC_SUB) begin
          state_nxt = ssh_pkg::ST_STOP; // see [R1]
          src_nxt   = cpu_clk_src;
        end else if (halt_req && !irq_pending) begin
          state_nxt = ssh_pkg::ST_HALT; // see [R2]
          src_nxt   = cpu_clk_src;
        end
      end
      ssh_pkg::ST_HALT: begin
        if (irq_pending) begin
          state_nxt = ssh_pkg::ST_RUN;
        end
      end
      ssh_pkg::ST_STOP: begin
        if (irq_pending) begin
          hold_cnt_nxt = ssh_pkg::HOLD_RST;
          state_nxt    = (src_r == ssh_pkg::SRC_RING) ?
                         ssh_pkg::ST_RING_HOLD : ssh_pkg::ST_OSC_WAIT; // see [R15]
        end
      end
      ssh_pkg::ST_OSC_WAIT: begin
        if (stab_done) begin
          state_nxt = ssh_pkg::ST_RUN; // see [R15] [R10]
        end
      end
      ssh_pkg::ST_RING_HOLD: begin
        if (ring_edge) begin
          if (hold_cnt_r == ssh_pkg::RING_HOLD_PERIODS - 5'h01) begin
            state_nxt = ssh_pkg::ST_RUN; // see [R5]
          end else begin
            hold_cnt_nxt = hold_cnt_r + 5'h01;
          end
        end
      end
      default: state_nxt = ssh_pkg::ST_OSC_WAIT;
    endcase
    // crystal off only in STOP, ring follows software bit only
    osc_ctl_nxt.main_osc_en = (state_nxt != ssh_pkg::ST_STOP); // see [R3]
    osc_ctl_nxt.internal_ring_oscillator_en = ~ring_stop_r; // see [R4]
    osc_ctl_nxt.cpu_clk_en  = (state_nxt == ssh_pkg::ST_RUN);
  end

  assign stab_clear = (state_r != ssh_pkg::ST_STOP) &&
                      (state_nxt == ssh_pkg::ST_STOP);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r    <= ssh_pkg::ST_OSC_WAIT;
      src_r      <= ssh_pkg::SRC_MAIN;
      hold_cnt_r <= ssh_pkg::HOLD_RST;
      osc_ctl_r  <= ssh_pkg::OSC_CTL_RST;
    end else begin
      state_r    <= state_nxt;
      src_r      <= src_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      osc_ctl_r  <= osc_ctl_nxt;
    end
  end

  ssh_stab_cnt #(.STAB_BASE(STAB_BASE), .CW(16)) u_stab (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clear   (stab_clear),
    .osc_ok  (osc_ok_s & osc_ctl_r.main_osc_en), // see [R10]
    .sel     (sel_r),
    .status  (stab_status),
    .done    (stab_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register slave: one wait cycle, then the access completes
  assign wr_go = avs_write && !wait_r;
  always_comb begin
    wait_nxt  = !((avs_read || avs_write) && wait_r);
    ring_stop_nxt = ring_stop_r;
    sel_nxt       = sel_r;
    rdata_nxt     = rdata_r;
    if (wr_go && avs_address == ssh_pkg::ADDR_CTRL && mask_ok_s) begin
      ring_stop_nxt = avs_writedata[ssh_pkg::CTRL_RING_STOP_POS]; // see [R6]
    end
    if (wr_go && avs_address == ssh_pkg::ADDR_SEL) begin
      sel_nxt = avs_writedata[2:0];
    end
    if (avs_read && wait_r) begin
      case (avs_address)
        ssh_pkg::ADDR_CTRL: rdata_nxt = {31'h0, ring_stop_r};
        ssh_pkg::ADDR_SEL:  rdata_nxt = {29'h0, sel_r};
        ssh_pkg::ADDR_STAT: rdata_nxt = {27'h0, stab_status};
        ssh_pkg::ADDR_MODE: rdata_nxt = {26'h0, src_r, 1'b0, state_r};
        default:            rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_r      <= 1'b1;
      ring_stop_r <= 1'b0;
      sel_r       <= ssh_pkg::SEL_RST;
      rdata_r     <= 32'h0;
    end else begin
      wait_r      <= wait_nxt;
      ring_stop_r <= ring_stop_nxt;
      sel_r   <= sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign osc_ctl         = osc_ctl_r;
  assign standby_state   = state_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_stop_src;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(state_r == ssh_pkg::ST_STOP) |-> $past(cpu_clk_src) != ssh_pkg::SRC_SUB;
  endproperty
  a_stop_src: assert property (p_stop_src) else $error("stop from sub"); // [R1]

  property p_halt_entry;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ssh_pkg::ST_RUN && halt_req && !stop_req && !irq_pending)
      |=> state_r == ssh_pkg::ST_HALT;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("no halt"); // [R2]

  property p_main_off;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ssh_pkg::ST_STOP) |-> !osc_ctl_r.main_osc_en;
  endproperty
  a_main_off: assert property (p_main_off) else $error("crystal on"); // [R3]

  property p_ring_kept;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ssh_pkg::ST_STOP && $past(state_r) == ssh_pkg::ST_STOP)
      |-> $stable(osc_ctl_r.internal_ring_oscillator_en);
  endproperty
  a_ring_kept: assert property (p_ring_kept) else $error("ring moved"); // [R4]

  property p_ring_hold;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ssh_pkg::ST_RING_HOLD && state_nxt == ssh_pkg::ST_RUN)
      |-> hold_cnt_r == 5'h10 && !osc_ctl_r.cpu_clk_en;
  endproperty
  a_ring_hold: assert property (p_ring_hold) else $error("hold count"); // [R5]

  property p_ring_stop_mask;
    @(posedge clk_sys) disable iff (!nrst)
    (wr_go && avs_address == ssh_pkg::ADDR_CTRL && !mask_ok_s)
      |=> $stable(ring_stop_r);
  endproperty
  a_ring_stop_mask: assert property (p_ring_stop_mask) else $error("stop bit"); // [R6]

  property p_stat_order;
    @(posedge clk_sys) disable iff (!nrst)
    !stab_clear |=> ((stab_status & $past(stab_status)) == $past(stab_status))
      && (stab_status[3:0] & ~stab_status[4:1]) == 4'h0;
  endproperty
  a_stat_order: assert property (p_stat_order) else $error("status"); // [R7]

  property p_stat_frozen;
    @(posedge clk_sys) disable iff (!nrst)
    // the last status bit lands one cycle after done rises
    (stab_done && $past(stab_done) && !stab_clear) |=> $stable(stab_status);
  endproperty
  a_stat_frozen: assert property (p_stat_frozen) else $error("late"); // [R8]

  property p_wait_osc;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ssh_pkg::ST_OSC_WAIT && !stab_done && !osc_ok_s)
      |=> state_r == ssh_pkg::ST_OSC_WAIT && !osc_ctl_r.cpu_clk_en;
  endproperty
  a_wait_osc: assert property (p_wait_osc) else $error("early run"); // [R10]

  property p_cancel;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ssh_pkg::ST_RUN && stop_req && irq_pending)
      |=> state_r == ssh_pkg::ST_HALT;
  endproperty
  a_cancel: assert property (p_cancel) else $error("no fallback"); // [R13]

  property p_resume;
    @(posedge clk_sys) disable iff (!nrst)
    (state_r == ssh_pkg::ST_OSC_WAIT && stab_done) |=> osc_ctl_r.cpu_clk_en;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // [R15]

  c_stop_main: cover property (@(posedge clk_sys) disable iff (!nrst)
    state_r == ssh_pkg::ST_OSC_WAIT ##1 state_r == ssh_pkg::ST_RUN);
  c_ring_hold: cover property (@(posedge clk_sys) disable iff (!nrst)
    state_r == ssh_pkg::ST_RING_HOLD ##1 state_r == ssh_pkg::ST_RUN);
  c_fallback: cover property (@(posedge clk_sys) disable iff (!nrst)
    state_r == ssh_pkg::ST_RUN && stop_req && irq_pending);
endmodule // ssh_standby_ctl
